// *** hw/tcmd_pkg.sv ***
/*
 Package for the compare output and waveform mode decode block.
 Assumes a single 200 MHz clock and a plain register port.
*/
package tcmd_pkg;
   // Register indices
   localparam logic [2:0] ADDR_CTRL_A = 3'h0;
   localparam logic [2:0] ADDR_CTRL_B = 3'h1;
   localparam logic [2:0] ADDR_COUNT = 3'h2;
   localparam logic [2:0] ADDR_CMP_A = 3'h3;
   localparam logic [2:0] ADDR_CMP_B = 3'h4;
   localparam logic [2:0] ADDR_STATUS = 3'h5;
   localparam logic [2:0] ADDR_MASK = 3'h6;
   // Field positions
   localparam int CTRL_A_MODE_HI = 7;
   localparam int CTRL_B_MODE_HI = 5;
   localparam int CTRL_WAVE_LOW_HI = 1;
   localparam int CTRLB_WAVE_HIGH = 3;
   localparam logic [7:0] CTRL_A_WMASK = 8'hF3;
   localparam logic [7:0] CTRL_B_WMASK = 8'h08;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // Status bits
   localparam int ST_OVF = 0;
   localparam int ST_MATCH_A = 1;
   localparam int ST_MATCH_B = 2;
   localparam logic [2:0] ST_RESET = 3'h0;
   // Counter limits
   localparam logic [7:0] CNT_MAX = 8'hFF;
   localparam logic [7:0] CNT_BOTTOM = 8'h00;
   // Waveform modes
   localparam logic [2:0] WM_NORMAL = 3'h0;
   localparam logic [2:0] WM_PC_FF = 3'h1;
   localparam logic [2:0] WM_CLR_MATCH = 3'h2;
   localparam logic [2:0] WM_FAST_FF = 3'h3;
   localparam logic [2:0] WM_PC_CMP = 3'h5;
   localparam logic [2:0] WM_FAST_CMP = 3'h7;
   // Output mode codes
   localparam logic [1:0] OM_OFF = 2'h0;
   localparam logic [1:0] OM_TOGGLE = 2'h1;
   localparam logic [1:0] OM_CLEAR = 2'h2;
   localparam logic [1:0] OM_SET = 2'h3;
   typedef enum logic [1:0] {FAM_NONPWM, FAM_FAST, FAM_PHASE, FAM_RSVD}
      tcmd_family_t;
endpackage

// *** hw/tcmd_top.sv ***
/*
 Timer with two compare channels and output mode decode.
 Assumes synchronous inputs, a timer tick from an outside prescaler,
 and port pin logic that takes the pin drive and enable signals.
*/
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
module tcmd_top (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic TICK_IN,
   input wire logic [2:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   output logic [7:0] RDATA_OUT,
   input wire logic [1:0] PORT_DIR_IN,
   input wire logic [1:0] PORT_DATA_IN,
   output logic [1:0] PIN_OUT,
   output logic [1:0] PIN_OE_OUT,
   output logic IRQ_OUT
);
   import tcmd_pkg::*;

   typedef struct packed {
      logic [7:0] ctrl_a;
      logic wave_high;
      logic [7:0] count;
      logic count_down;
      logic [7:0] cmp_buf_a;
      logic [7:0] cmp_buf_b;
      logic [7:0] cmp_act_a;
      logic [7:0] cmp_act_b;
      logic [1:0] wave;
      logic [2:0] status;
      logic [2:0] mask;
      logic [7:0] rdata;
      logic [1:0] pin;
      logic [1:0] pin_oe;
      logic irq;
   } tcmd_state_t;

   tcmd_state_t r;
   tcmd_state_t next_r;

   // ---------------------------------------------------------------
   // Mode decode
   // ---------------------------------------------------------------
   logic [2:0] wmode;
   tcmd_family_t fam;
   logic [7:0] top;
   logic at_top;
   logic at_bottom;
   logic [1:0][1:0] om;
   logic [1:0][7:0] cmp;
   logic [1:0] match;

   assign wmode = {r.wave_high, r.ctrl_a[CTRL_WAVE_LOW_HI:0]};
   assign om[0] = r.ctrl_a[CTRL_A_MODE_HI -: 2];
   assign om[1] = r.ctrl_a[CTRL_B_MODE_HI -: 2];
   assign cmp[0] = r.cmp_act_a;
   assign cmp[1] = r.cmp_act_b;

   // Family and top source
   always_comb begin
      case (wmode)
         WM_NORMAL, WM_CLR_MATCH: fam = FAM_NONPWM;
         WM_FAST_FF, WM_FAST_CMP: fam = FAM_FAST;
         WM_PC_FF, WM_PC_CMP: fam = FAM_PHASE;
         default: fam = FAM_RSVD;
      endcase
      case (wmode)
         WM_CLR_MATCH, WM_FAST_CMP, WM_PC_CMP: top = r.cmp_act_a;
         default: top = CNT_MAX;
      endcase
   end

   assign at_top = (r.count == top);
   assign at_bottom = (r.count == CNT_BOTTOM);

   // Per channel compare
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_cmp
         assign match[gi] = TICK_IN && (r.count == cmp[gi]);
      end
   endgenerate

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      logic upd;
      logic ovf;
      logic [1:0] nw;
      logic [1:0] conn;
      logic [2:0] clr;
      logic [2:0] ev;
      upd = 1'b0;
      ovf = 1'b0;
      nw = r.wave;
      conn = 2'b00;
      clr = 3'b000;
      ev = 3'b000;
      next_r = r;

      // Counter sequencing
      if (TICK_IN) begin
         case (fam)
            FAM_PHASE: begin
               if (!r.count_down && at_top) begin
                  next_r.count_down = 1'b1;
                  next_r.count = r.count - 8'h01;
               end else if (r.count_down && at_bottom) begin
                  next_r.count_down = 1'b0;
                  next_r.count = r.count + 8'h01;
               end else if (r.count_down) begin
                  next_r.count = r.count - 8'h01;
               end else begin
                  next_r.count = r.count + 8'h01;
               end
            end
            default: begin
               next_r.count_down = 1'b0;
               next_r.count = at_top ? CNT_BOTTOM : r.count + 8'h01;
            end
         endcase
         // Buffer update point
         case (wmode)
            WM_NORMAL, WM_CLR_MATCH: upd = 1'b1;
            WM_PC_FF, WM_FAST_FF, WM_PC_CMP: upd = at_top;
            WM_FAST_CMP: upd = at_bottom;
            default: upd = 1'b0;
         endcase
         // Overflow point
         case (wmode)
            WM_NORMAL, WM_CLR_MATCH, WM_FAST_FF:
               ovf = (r.count == CNT_MAX);
            WM_PC_FF, WM_PC_CMP: ovf = at_bottom && r.count_down;
            WM_FAST_CMP: ovf = at_top;
            default: ovf = 1'b0;
         endcase
      end
      if (wmode == WM_NORMAL || wmode == WM_CLR_MATCH) begin
         upd = 1'b1;
      end
      if (upd) begin
         next_r.cmp_act_a = r.cmp_buf_a;
         next_r.cmp_act_b = r.cmp_buf_b;
      end

      // Waveform per channel
      for (int c = 0; c < 2; c++) begin
         conn[c] = (om[c] != OM_OFF);
         case (fam)
            FAM_NONPWM: begin
               if (match[c]) begin
                  case (om[c])
                     OM_TOGGLE: nw[c] = ~r.wave[c];
                     OM_CLEAR: nw[c] = 1'b0;
                     OM_SET: nw[c] = 1'b1;
                     default: nw[c] = r.wave[c];
                  endcase
               end
            end
            FAM_FAST: begin
               if (om[c] == OM_TOGGLE) begin
                  conn[c] = (c == 0) && r.wave_high;
                  if (conn[c] && match[c]) nw[c] = ~r.wave[c];
               end else if (om[c][1]) begin
                  if (TICK_IN && at_top) begin
                     nw[c] = ~om[c][0];
                  end else if (match[c] && cmp[c] != top) begin
                     nw[c] = om[c][0];
                  end
               end
            end
            FAM_PHASE: begin
               if (om[c] == OM_TOGGLE) begin
                  conn[c] = (c == 0) && r.wave_high;
                  if (conn[c] && match[c]) nw[c] = ~r.wave[c];
               end else if (om[c][1]) begin
                  if (cmp[c] == top) begin
                     // Level at top matches a down-count match result
                     if (TICK_IN && at_top) begin
                        nw[c] = ~om[c][0];
                     end
                  end else if (match[c]) begin
                     // Up clears for 10, down sets; 11 inverted
                     nw[c] = om[c][0] ^ r.count_down;
                  end
               end
            end
            default: nw[c] = r.wave[c];
         endcase
      end
      next_r.wave = nw;

      // Register writes
      if (WR_IN) begin
         case (ADDR_IN)
            ADDR_CTRL_A:
               next_r.ctrl_a = WDATA_IN & CTRL_A_WMASK;
            ADDR_CTRL_B: next_r.wave_high = WDATA_IN[CTRLB_WAVE_HIGH];
            ADDR_COUNT: next_r.count = WDATA_IN;
            ADDR_CMP_A: next_r.cmp_buf_a = WDATA_IN;
            ADDR_CMP_B: next_r.cmp_buf_b = WDATA_IN;
            ADDR_STATUS: clr = WDATA_IN[2:0];
            ADDR_MASK: next_r.mask = WDATA_IN[2:0];
            default: ;
         endcase
      end

      // Sticky events, set wins over clear
      ev[ST_OVF] = ovf;
      ev[ST_MATCH_A] = match[0];
      ev[ST_MATCH_B] = match[1];
      next_r.status = (r.status & ~clr) | ev;

      // Read data, one cycle later
      next_r.rdata = 8'h00;
      if (RD_IN) begin
         case (ADDR_IN)
            ADDR_CTRL_A: next_r.rdata = r.ctrl_a & CTRL_A_WMASK;
            ADDR_CTRL_B:
               next_r.rdata = {4'h0, r.wave_high, 3'h0} & CTRL_B_WMASK;
            ADDR_COUNT: next_r.rdata = r.count;
            ADDR_CMP_A: next_r.rdata = r.cmp_buf_a;
            ADDR_CMP_B: next_r.rdata = r.cmp_buf_b;
            ADDR_STATUS: next_r.rdata = {5'h00, r.status};
            ADDR_MASK: next_r.rdata = {5'h00, r.mask};
            default: next_r.rdata = 8'h00;
         endcase
      end

      // Pin muxing and driver enable
      for (int c = 0; c < 2; c++) begin
         next_r.pin[c] = conn[c] ? nw[c] : PORT_DATA_IN[c];
         next_r.pin_oe[c] = PORT_DIR_IN[c];
      end
      next_r.irq = |(next_r.status & next_r.mask);
   end

   // State register
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         r <= '0;
         r.ctrl_a <= CTRL_RESET;
         r.status <= ST_RESET;
      end else begin
         r <= next_r;
      end
   end

   assign RDATA_OUT = r.rdata;
   assign PIN_OUT = r.pin;
   assign PIN_OE_OUT = r.pin_oe;
   assign IRQ_OUT = r.irq;
endmodule

// *** tb/tcmd_top_assertions.sv ***
/*
 Port checker for tcmd_top, bound to the design below.
 Assumes the register map of tcmd_pkg and shadows of software writes.
*/
`timescale 1ns/1ps
module tcmd_chk (
   input wire logic MCLK_IN,
   input wire logic RST_IN,
   input wire logic TICK_IN,
   input wire logic [2:0] ADDR_IN,
   input wire logic [7:0] WDATA_IN,
   input wire logic WR_IN,
   input wire logic RD_IN,
   input wire logic [7:0] RDATA_OUT,
   input wire logic [1:0] PORT_DIR_IN,
   input wire logic [1:0] PORT_DATA_IN,
   input wire logic [1:0] PIN_OUT,
   input wire logic [1:0] PIN_OE_OUT,
   input wire logic IRQ_OUT
);
   import tcmd_pkg::*;
   logic [7:0] sh;
   logic [2:0] msk;
   logic hb;
   default clocking cb @(posedge MCLK_IN);
   endclocking
   default disable iff (RST_IN);
   // Shadow of control and mask writes
   always_ff @(posedge MCLK_IN) begin
      if (RST_IN) begin
         sh <= 8'h00;
         msk <= 3'h0;
         hb <= 1'b0;
      end else if (WR_IN) begin
         if (ADDR_IN == ADDR_CTRL_A) sh <= WDATA_IN & CTRL_A_WMASK;
         if (ADDR_IN == ADDR_CTRL_B) hb <= WDATA_IN[CTRLB_WAVE_HIGH];
         if (ADDR_IN == ADDR_MASK) msk <= WDATA_IN[2:0];
      end
   end
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   AST_OE: assert property (!$past(RST_IN) |->
      PIN_OE_OUT == $past(PORT_DIR_IN)) else $error("enable not direction");
   AST_DISC_A: assert property (!$past(RST_IN) &&
      $past(sh[7:6]) == OM_OFF |-> PIN_OUT[0] == $past(PORT_DATA_IN[0]))
      else $error("pin a not port data");
   AST_DISC_B: assert property (!$past(RST_IN) &&
      $past(sh[5:4]) == OM_OFF |-> PIN_OUT[1] == $past(PORT_DATA_IN[1]))
      else $error("pin b not port data");
   AST_PWM_A01: assert property (!$past(RST_IN) && $past(sh[0]) &&
      !$past(hb) && $past(sh[7:6]) == OM_TOGGLE |->
      PIN_OUT[0] == $past(PORT_DATA_IN[0])) else $error("pwm a 01 driven");
   AST_RSV: assert property ($past(RD_IN) &&
      $past(ADDR_IN) == ADDR_CTRL_A |-> RDATA_OUT[3:2] == 2'h0)
      else $error("reserved bits not zero");
   AST_RB_CTRL: assert property ($past(RD_IN) &&
      $past(ADDR_IN) == ADDR_CTRL_A |-> RDATA_OUT == $past(sh))
      else $error("control a readback");
   AST_RB_HB: assert property ($past(RD_IN) &&
      $past(ADDR_IN) == ADDR_CTRL_B |-> RDATA_OUT[3] == $past(hb))
      else $error("wave high readback");
   AST_IRQ_MASK: assert property (!$past(RST_IN) &&
      msk == 3'h0 |-> !IRQ_OUT) else $error("masked irq high");
endmodule
bind tcmd_top tcmd_chk u_chk (.MCLK_IN(MCLK_IN), .RST_IN(RST_IN),
   .TICK_IN(TICK_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
   .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT),
   .PORT_DIR_IN(PORT_DIR_IN), .PORT_DATA_IN(PORT_DATA_IN),
   .PIN_OUT(PIN_OUT), .PIN_OE_OUT(PIN_OE_OUT), .IRQ_OUT(IRQ_OUT));

// *** tb/tcmd_pad_model.sv ***
/*
 Pad model for the two compare pins.
 Assumes each pad is pulled up while its driver is off.
*/
`timescale 1ns/1ps
module tcmd_pad (
   input wire logic [1:0] pin_in,
   input wire logic [1:0] oe_in,
   output logic [1:0] pad_out
);
   // Pad follows the driver, pull-up when released
   assign pad_out = (pin_in & oe_in) | ~oe_in;
endmodule

// *** tb/test_timer_compare_output_mode_decode.sv ***
/*
 Bench for tcmd_top: registers, pin handover, waveform modes, irq.
 Assumes tcmd_pkg, tcmd_pad and the bound checker.
*/
`timescale 1ns/1ps
module test_timer_compare_output_mode_decode;
   import tcmd_pkg::*;
   logic clk = 0, rst = 1, tick = 0, wr = 0, rd = 0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wd = 8'h00;
   logic [1:0] dir = 2'h3, pdat = 2'h0;
   logic [7:0] rdat;
   logic [1:0] pin, oe, pad;
   logic irq;
   logic [9:0] hia, tra, trb, bad;
   int fails = 0, checked = 0, cyc = 0;
   tcmd_top i_dut (.MCLK_IN(clk), .RST_IN(rst), .TICK_IN(tick),
      .ADDR_IN(addr), .WDATA_IN(wd), .WR_IN(wr), .RD_IN(rd),
      .RDATA_OUT(rdat), .PORT_DIR_IN(dir), .PORT_DATA_IN(pdat),
      .PIN_OUT(pin), .PIN_OE_OUT(oe), .IRQ_OUT(irq));
   tcmd_pad i_pad (.pin_in(pin), .oe_in(oe), .pad_out(pad));
   // Clock and hang limit
   initial begin
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fails = fails + 1;
         test_done();
      end
   end
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic chk(input string s, input logic [9:0] e, g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %0h seen %0h", s, e, g);
      end
   endtask
   task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [2:0] a, input logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 chk("read data", {2'h0, e}, {2'h0, rdat});
   endtask
   task automatic run(input int n);
      logic [1:0] p;
      {hia, tra, trb, bad} = '0;
      #1 p = pin;
      repeat (n) begin
         @(posedge clk);
         #1 hia += {9'h0, pin[0] === 1'b1};
         tra += {9'h0, pin[0] !== p[0]};
         trb += {9'h0, pin[1] !== p[1]};
         bad += {9'h0, pin[1] === pin[0]};
         p = pin;
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_regs();
      rd_reg(ADDR_CTRL_A, CTRL_RESET);
      wr_reg(ADDR_CTRL_A, 8'hFF);
      rd_reg(ADDR_CTRL_A, 8'hF3);
      wr_reg(ADDR_CTRL_B, 8'h08);
      rd_reg(ADDR_CTRL_B, 8'h08);
      wr_reg(ADDR_CTRL_B, 8'h00);
      wr_reg(ADDR_CTRL_A, 8'h00);
      rd_reg(3'h7, 8'h00);
      $display("t_regs done");
   endtask
   task automatic t_port();
      pdat <= 2'h0;
      dir <= 2'h2;
      run(3);
      chk("pad", 10'h001, {8'h00, pad});
      chk("enable", 10'h002, {8'h00, oe});
      pdat <= 2'h3;
      dir <= 2'h3;
      wr_reg(ADDR_CTRL_A, {OM_TOGGLE, OM_OFF, 4'h3});
      run(300);
      chk("port data", 10'h003, {8'h00, pin});
      pdat <= 2'h0;
      $display("t_port done");
   endtask
   task automatic t_nonpwm();
      wr_reg(ADDR_CTRL_A, 8'h00);
      wr_reg(ADDR_CMP_A, 8'h0A);
      wr_reg(ADDR_CMP_B, 8'h14);
      for (int i = 3; i >= 2; i--) begin
         wr_reg(ADDR_CTRL_A, {i[1:0], i[1:0], 4'h0});
         run(260);
         chk("set clear", {8'h00, i[0], i[0]}, {8'h00, pin});
      end
      wr_reg(ADDR_CTRL_A, {OM_TOGGLE, OM_TOGGLE, 4'h0});
      run(512);
      chk("toggle a", 10'h002, tra);
      chk("toggle b", 10'h002, trb);
      $display("t_nonpwm done");
   endtask
   task automatic t_fast();
      wr_reg(ADDR_CMP_A, 8'h40);
      wr_reg(ADDR_CMP_B, 8'h40);
      wr_reg(ADDR_CTRL_A, {OM_CLEAR, OM_SET, 2'h0, 2'h3});
      run(300);
      run(256);
      chk("fast complement", 10'h000, bad);
      chk("fast duty", 10'h001, {9'h0, hia > 62 && hia < 66});
      wr_reg(ADDR_CMP_A, CNT_MAX);
      wr_reg(ADDR_CMP_B, CNT_MAX);
      run(600);
      run(256);
      chk("fast top a", 10'h100, hia);
      chk("fast top b", 10'h000, trb);
      $display("t_fast done");
   endtask
   task automatic t_phase();
      wr_reg(ADDR_CMP_A, 8'h40);
      wr_reg(ADDR_CMP_B, 8'h40);
      wr_reg(ADDR_CTRL_A, {OM_CLEAR, OM_SET, 2'h0, 2'h1});
      run(1100);
      run(510);
      chk("phase complement", 10'h000, bad);
      chk("phase duty", 10'h001, {9'h0, hia > 125 && hia < 131});
      wr_reg(ADDR_CMP_A, CNT_MAX);
      run(1100);
      run(510);
      chk("phase top a", 10'h000, tra);
      chk("phase top a level", 10'h1FE, hia);
      $display("t_phase done");
   endtask
   task automatic t_top();
      logic [2:0] m;
      wr_reg(ADDR_CTRL_A, 8'h00);
      wr_reg(ADDR_CMP_A, 8'h09);
      for (int i = 0; i < 3; i++) begin
         m = i == 0 ? WM_CLR_MATCH : i == 1 ? WM_FAST_CMP : WM_PC_CMP;
         wr_reg(ADDR_CTRL_B, {4'h0, m[2], 3'h0});
         wr_reg(ADDR_CTRL_A, {OM_TOGGLE, OM_OFF, 2'h0, m[1:0]});
         run(600);
         run(180);
         chk("top period", i == 2 ? 10'h00A : 10'h012, tra);
      end
      $display("t_top done");
   endtask
   task automatic t_irq();
      wr_reg(ADDR_CTRL_B, 8'h00);
      wr_reg(ADDR_CTRL_A, 8'h00);
      run(260);
      rd_reg(ADDR_STATUS, 8'h07);
      chk("masked irq", 10'h000, {9'h0, irq});
      tick <= 1'b0;
      wr_reg(ADDR_STATUS, 8'h07);
      rd_reg(ADDR_STATUS, 8'h00);
      wr_reg(ADDR_MASK, 8'h01);
      tick <= 1'b1;
      run(260);
      chk("irq raised", 10'h001, {9'h0, irq});
      tick <= 1'b0;
      wr_reg(ADDR_STATUS, 8'h01);
      run(3);
      chk("irq cleared", 10'h000, {9'h0, irq});
      $display("t_irq done");
   endtask
   task automatic test_done();
      $display("checked %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      tick <= 1'b1;
      t_regs();
      t_port();
      t_nonpwm();
      t_fast();
      t_phase();
      t_top();
      t_irq();
      test_done();
   end
endmodule
